// ===== verification/rci_store_model.sv
// Behavioural parameter store and report engine beside the interpreter
`timescale 1ns/10ps
`default_nettype none
module rci_store_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic commit_in,
	input wire logic query_in,
	input wire logic q_ok_in,
	input wire logic q_multi_in,
	input wire logic [3:0] delay_in,
	output logic set_done_out,
	output logic set_ok_out,
	output logic query_done_out,
	output logic query_ok_out,
	output logic query_multi_out
);
	logic [3:0] cnt_ff;
	logic set_ff;
	logic qry_ff;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			{cnt_ff, set_ff, qry_ff, set_done_out, query_done_out} <= '0;
		end else begin
			set_done_out <= 1'b0;
			query_done_out <= 1'b0;
			if (commit_in || query_in) begin
				cnt_ff <= delay_in;
				set_ff <= commit_in;
				qry_ff <= query_in;
			end else if (set_ff || qry_ff) begin
				if (cnt_ff == 4'h0) begin
					set_done_out <= set_ff;
					query_done_out <= qry_ff;
					set_ff <= 1'b0;
					qry_ff <= 1'b0;
				end else begin
					cnt_ff <= cnt_ff - 4'h1;
				end
			end
		end
	end
	// Qualifiers only mean something with their done pulse, so they wander otherwise
	assign set_ok_out = set_done_out ? q_ok_in : cnt_ff[0];
	assign query_ok_out = query_done_out ? q_ok_in : ~q_ok_in;
	assign query_multi_out = query_done_out ? q_multi_in : cnt_ff[1];
endmodule : rci_store_model
`default_nettype wire

// ===== verification/test_receiver_command_interpreter.sv
// Self-checking bench of the receiver command interpreter
`timescale 1ns/10ps
`default_nettype none
module test_receiver_command_interpreter;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] rx_byte = 8'h00;
	logic rx_valid = 1'b0;
	logic rdy = 1'b1;
	logic q_ok = 1'b1;
	logic q_multi = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [7:0] tx_byte, code, sub, idx, wdata, slen, rkind, wlast;
	logic [6:0] waddr, walast;
	logic tx_valid, set_wr, commit, qreq, rreq, boot, par, idxd, s_done, s_ok, q_done, q_okd, q_mul;
	logic [17:0] baud;
	logic [7:0] ack [9];
	int err_total = 0;
	int checks = 0;
	int cycles = 0;
	int n_commit = 0;
	int n_query = 0;
	int n_reset = 0;
	rci_cmd_interp dut_u (.SYS_CLK_IN(clk), .RST_IN(rst), .RX_BYTE_IN(rx_byte), .RX_VALID_IN(rx_valid),
		.TX_BYTE_OUT(tx_byte), .TX_VALID_OUT(tx_valid), .TX_READY_IN(rdy), .CODE_OUT(code), .SUB_OUT(sub),
		.INDEX_OUT(idx), .INDEXED_OUT(idxd), .SET_WR_OUT(set_wr), .SET_WADDR_OUT(waddr), .SET_WDATA_OUT(wdata),
		.SET_COMMIT_OUT(commit), .SET_LEN_OUT(slen), .SET_DONE_IN(s_done), .SET_OK_IN(s_ok),
		.QUERY_REQ_OUT(qreq), .QUERY_DONE_IN(q_done), .QUERY_OK_IN(q_okd), .QUERY_MULTI_IN(q_mul),
		.RESET_REQ_OUT(rreq), .RESET_KIND_OUT(rkind), .BOOT_MODE_OUT(boot), .BAUD_RATE_OUT(baud),
		.PARITY_EVEN_OUT(par));
	rci_store_model store_u (.clk_in(clk), .rst_in(rst), .commit_in(commit), .query_in(qreq),
		.q_ok_in(q_ok), .q_multi_in(q_multi), .delay_in(dly), .set_done_out(s_done), .set_ok_out(s_ok),
		.query_done_out(q_done), .query_ok_out(q_okd), .query_multi_out(q_mul));
	initial begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		n_commit += (commit === 1'b1);
		n_query += (qreq === 1'b1);
		n_reset += (rreq === 1'b1);
		if (set_wr === 1'b1) wlast <= wdata;
		if (set_wr === 1'b1) walast <= waddr;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Frames the payload, appends a checksum and stuffs control-range bytes after the first two payload bytes
	task automatic send(input logic [7:0] p[$], input bit bad);
		logic [7:0] s[$];
		logic [7:0] cs;
		cs = 8'h00 - 8'h81 - 8'h82 + {7'h00, bad};
		foreach (p[i]) cs -= p[i];
		p.push_back(cs);
		s.push_back(8'h81);
		foreach (p[i]) begin
			if (i > 1 && p[i] >= 8'h80 && p[i] <= 8'h87) begin
				s.push_back(8'h80);
				s.push_back(p[i] & 8'h7F);
			end else begin
				s.push_back(p[i]);
			end
		end
		s.push_back(8'h82);
		rx_valid = 1'b1;
		foreach (s[i]) begin
			rx_byte = s[i];
			tick();
		end
		rx_valid = 1'b0;
	endtask : send
	task automatic chk_ack(input logic [7:0] st, input logic [7:0] cc, input logic [7:0] pc, input bit slow);
		int n;
		bit esc;
		logic [7:0] sum;
		n = 0;
		esc = 1'b0;
		sum = 8'h00;
		for (int t = 0; t < 300 && n < 9; t++) begin
			@(posedge clk);
			if (tx_valid === 1'b1 && rdy === 1'b1) begin
				if (tx_byte === 8'h80 && n > 1 && !esc) begin
					esc = 1'b1;
				end else begin
					ack[n] = esc ? (tx_byte | 8'h80) : tx_byte;
					esc = 1'b0;
					n++;
				end
			end
			#1;
			rdy = slow ? ~rdy : 1'b1;
		end
		chk("ack length", n, 9);
		foreach (ack[i]) sum += ack[i];
		chk("ack start", ack[0], 8'h81);
		chk("ack end", ack[8], 8'h82);
		chk("ack parser", ack[1], 8'h10);
		chk("ack class", ack[3], cc);
		chk("ack code", ack[4], pc);
		chk("ack status", ack[6], st);
		chk("ack sum", sum, 8'h00);
	endtask : chk_ack
	task automatic no_ack(input int n);
		int seen = 0;
		repeat (n) begin
			@(posedge clk);
			seen += (tx_valid === 1'b1);
		end
		#1;
		chk("silent", seen, 0);
	endtask : no_ack
	task automatic t_set();
		send('{8'h01, 8'h24, 8'h01, 8'h3C, 8'h85}, 1'b0);
		chk_ack(8'h00, 8'h01, 8'h24, 1'b0);
		chk("commit", n_commit, 1);
		chk("data", wlast, 8'h85);
		chk("data offset", walast, 7'h01);
		chk("data length", slen, 8'h02);
		chk("code", code, 8'h24);
		chk("subcode", sub, 8'h01);
		send('{8'h01, 8'h30, 8'h01, 8'h03}, 1'b0);
		chk_ack(8'h02, 8'h01, 8'h30, 1'b1);
		send('{8'h04, 8'h24, 8'h01}, 1'b0);
		chk_ack(8'h02, 8'h04, 8'h24, 1'b0);
		send('{8'h01, 8'h24, 8'h01}, 1'b0);
		chk_ack(8'h03, 8'h01, 8'h24, 1'b0);
		// The store refuses this one, so the acknowledgment must report failure
		q_ok = 1'b0;
		send('{8'h01, 8'h25, 8'h00, 8'h07}, 1'b0);
		chk_ack(8'h01, 8'h01, 8'h25, 1'b0);
		q_ok = 1'b1;
		chk("fail commit", n_commit, 2);
		send('{8'h01, 8'h24, 8'h01, 8'h03}, 1'b1);
		no_ack(40);
		chk("no commit", n_commit, 2);
	endtask : t_set
	task automatic t_query();
		dly = 4'h5;
		send('{8'h02, 8'h24, 8'h01}, 1'b0);
		no_ack(60);
		chk("query", n_query, 1);
		q_multi = 1'b1;
		send('{8'h02, 8'h24, 8'h01}, 1'b0);
		chk_ack(8'h00, 8'h02, 8'h24, 1'b1);
		q_multi = 1'b0;
		q_ok = 1'b0;
		send('{8'h02, 8'h24, 8'h02}, 1'b0);
		chk_ack(8'h01, 8'h02, 8'h24, 1'b0);
		q_ok = 1'b1;
		send('{8'h02, 8'h24, 8'hFF}, 1'b0);
		chk_ack(8'h00, 8'h02, 8'h24, 1'b0);
		send('{8'h02, 8'h24, 8'h01, 8'hFF}, 1'b0);
		chk_ack(8'h00, 8'h02, 8'h24, 1'b0);
		chk("index", idx, 8'hFF);
		chk("indexed", idxd, 1'b1);
		// Subcode in the control range comes back stuffed inside the acknowledgment
		send('{8'h02, 8'h24, 8'h85}, 1'b0);
		chk_ack(8'h02, 8'h02, 8'h24, 1'b1);
		chk("queries", n_query, 5);
	endtask : t_query
	task automatic t_reset();
		logic [7:0] kinds [5] = '{8'h01, 8'h02, 8'h05, 8'h07, 8'h09};
		foreach (kinds[k]) begin
			send('{8'h03, kinds[k]}, 1'b0);
			chk("early reset", n_reset, k);
			chk_ack(8'h00, 8'h03, kinds[k], 1'b0);
			repeat (4) tick();
			chk("reset", n_reset, k + 1);
			chk("kind", rkind, kinds[k]);
		end
		send('{8'h03, 8'h04}, 1'b0);
		chk_ack(8'h02, 8'h03, 8'h04, 1'b0);
		chk("baud", baud, 18'd9600);
		send('{8'h03, 8'h03}, 1'b0);
		chk_ack(8'h00, 8'h03, 8'h03, 1'b0);
		repeat (5) tick();
		chk("boot", boot, 1'b1);
		chk("boot baud", baud, 18'd115200);
		chk("parity", par, 1'b1);
		send('{8'h02, 8'h24, 8'h01}, 1'b0);
		no_ack(60);
		chk("boot query", n_query, 5);
		rst = 1'b1;
		tick();
		rst = 1'b0;
		chk("boot cleared", boot, 1'b0);
		chk("baud restored", baud, 18'd9600);
		chk("parity cleared", par, 1'b0);
	endtask : t_reset
	task automatic results();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	initial begin
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("boot idle", boot, 1'b0);
		t_set();
		t_query();
		t_reset();
		results();
	end
endmodule : test_receiver_command_interpreter
`default_nettype wire

// ===== verilog/rci_cmd_interp.sv
// Receiver command interpreter: command decode, dispatch and acknowledgment framing
// Contract
// [R1] Set, system, failed and multi-report queries get an explicit 0x10 acknowledgment.
// [R2] A query answered by exactly one report gets no separate acknowledgment.
// [R3] A multi-report query gets its acknowledgment right after the final report.
// [R4] A query that cannot be served gets only an acknowledgment, no report.
// [R5] Every acknowledgment carries a completion status byte.
// [R6] Set command: code 0x01, parser code, subcode 0x00-7F, fixed-length data.
// [R7] Indexed set commands carry one index byte before the data.
// [R8] A set is answered only by acknowledgment, data never echoed.
// [R9] Query: code 0x02, parser code, subcode; 0xFF asks all subcodes.
// [R10] Indexed query adds index byte; 0x00-7F one index, 0xFF all.
// [R11] Decode reset code 0x03 with subcodes 01, 02, 03, 05, 07, 09.
// [R12] Bootloader subcode leaves navigation and sets link to 115.2 kbps even parity.
// [R13] In bootloader mode every protocol command is ignored.
// [R14] Only configuration and initialization parameters are settable.
// [R15] Frames start with 0x81, end with 0x82, checksum just before end.
// [R16] Bytes from start to end sum to zero, else the frame is ignored.
// [R17] Data or checksum bytes 0x80-0x87 go out as 0x80 plus low seven bits.
// [R18] Received escape yields nothing; the next byte is ORed with 0x80.
// [R19] Unknown codes get an error acknowledgment and change nothing.
// [R20] Resets act only after a valid frame and after the acknowledgment is sent.
`timescale 1ns/10ps
`default_nettype none
module rci_cmd_interp #(
	parameter logic [127:0] SETTABLE_MAP = 128'h0000_0000_0000_0000_0000_0030_0000_0000,
	parameter logic [127:0] INDEXED_MAP = 128'h0000_0000_0000_0000_0000_0000_0000_0000,
	parameter logic [17:0] NORMAL_BAUD = rci_pkg::NORMAL_BAUD_BPS
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] RX_BYTE_IN,
	input wire logic RX_VALID_IN,
	output logic [7:0] TX_BYTE_OUT,
	output logic TX_VALID_OUT,
	input wire logic TX_READY_IN,
	output logic [7:0] CODE_OUT,
	output logic [7:0] SUB_OUT,
	output logic [7:0] INDEX_OUT,
	output logic INDEXED_OUT,
	output logic SET_WR_OUT,
	output logic [6:0] SET_WADDR_OUT,
	output logic [7:0] SET_WDATA_OUT,
	output logic SET_COMMIT_OUT,
	output logic [7:0] SET_LEN_OUT,
	input wire logic SET_DONE_IN,
	input wire logic SET_OK_IN,
	output logic QUERY_REQ_OUT,
	input wire logic QUERY_DONE_IN,
	input wire logic QUERY_OK_IN,
	input wire logic QUERY_MULTI_IN,
	output logic RESET_REQ_OUT,
	output logic [7:0] RESET_KIND_OUT,
	output logic BOOT_MODE_OUT,
	output logic [17:0] BAUD_RATE_OUT,
	output logic PARITY_EVEN_OUT
);
	rci_pkg::rci_state_t state_ff;
	logic [7:0] rx_mbyte;
	logic rx_mvalid, rx_start, rx_end, rx_ok;
	logic armed_ff, idx_seen_ff, multi_ff, post_ff, post_boot_ff, tx_half_ff;
	logic [7:0] pos_ff, command_class_code_ff, parser_code_ff, parser_subcode_ff, index_ff, status_ff;
	logic [7:0] post_kind_ff;
	logic [3:0] tx_idx_ff;
	logic code_ok, sub_one, sub_all, indexed, settable, idx_ok, sys_sub_ok, frame_go, tx_acc, tx_last_acc;
	logic [7:0] hdr_len, data_cnt, ack_sum, cur_byte, next_byte;
	logic [3:0] next_idx;

	rci_rx_deframe u_deframe (
		.clk_in(SYS_CLK_IN),
		.rst_in(RST_IN),
		.byte_in(RX_BYTE_IN),
		.valid_in(RX_VALID_IN),
		.mbyte_out(rx_mbyte),
		.mvalid_out(rx_mvalid),
		.start_out(rx_start),
		.end_out(rx_end),
		.ok_out(rx_ok)
	);

	function automatic logic [7:0] ack_byte(input logic [3:0] idx, input logic [7:0] cc, input logic [7:0] pc,
		input logic [7:0] ps, input logic [7:0] st, input logic [7:0] cs);
		case (idx)
			4'd0: ack_byte = rci_pkg::FRAME_START_BYTE;
			4'd1: ack_byte = rci_pkg::ACK_PARSER_CODE;
			4'd2: ack_byte = rci_pkg::ACK_PARSER_SUBCODE;
			4'd3: ack_byte = cc;
			4'd4: ack_byte = pc;
			4'd5: ack_byte = ps;
			4'd6: ack_byte = st;
			4'd7: ack_byte = cs;
			default: ack_byte = rci_pkg::FRAME_END_BYTE;
		endcase
	endfunction : ack_byte

	always_comb begin
		code_ok = parser_code_ff <= rci_pkg::CODE_MAX;
		sub_one = parser_subcode_ff <= rci_pkg::CODE_MAX;
		sub_all = parser_subcode_ff == rci_pkg::SELECT_ALL;
		indexed = code_ok && INDEXED_MAP[parser_code_ff[6:0]];
		settable = code_ok && SETTABLE_MAP[parser_code_ff[6:0]]; // [R14]
		idx_ok = !idx_seen_ff || index_ff <= rci_pkg::CODE_MAX || index_ff == rci_pkg::SELECT_ALL; // [R10]
		hdr_len = indexed ? rci_pkg::HDR_LEN_INDEXED : rci_pkg::HDR_LEN_PLAIN; // [R7]
		data_cnt = 8'(pos_ff - hdr_len);
		sys_sub_ok = (parser_code_ff == rci_pkg::RST_PLAIN) || (parser_code_ff == rci_pkg::RST_CLEAR_RAM) // [R11]
			|| (parser_code_ff == rci_pkg::RST_BOOTLOADER) || (parser_code_ff == rci_pkg::RST_CLEAR_EPH)
			|| (parser_code_ff == rci_pkg::RST_CLEAR_FLASH) || (parser_code_ff == rci_pkg::RST_SAVE_BBM);
		frame_go = rx_end && rx_ok && armed_ff && !BOOT_MODE_OUT; // [R13] [R16]
		ack_sum = 8'(8'h00 - rci_pkg::FRAME_START_BYTE - rci_pkg::ACK_PARSER_CODE - rci_pkg::ACK_PARSER_SUBCODE
			- command_class_code_ff - parser_code_ff - parser_subcode_ff - status_ff - rci_pkg::FRAME_END_BYTE);
		next_idx = 4'(tx_idx_ff + 4'd1);
		cur_byte = ack_byte(tx_idx_ff, command_class_code_ff, parser_code_ff, parser_subcode_ff, status_ff, ack_sum);
		next_byte = ack_byte(next_idx, command_class_code_ff, parser_code_ff, parser_subcode_ff, status_ff, ack_sum);
		tx_acc = state_ff == rci_pkg::RCI_ACK_SEND && TX_VALID_OUT && TX_READY_IN;
		tx_last_acc = tx_acc && tx_idx_ff == rci_pkg::ACK_LAST_IDX && !tx_half_ff;
	end

	// Field capture; frames that start while a command is in flight are dropped whole
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			armed_ff <= 1'b0;
			pos_ff <= 8'h00;
			command_class_code_ff <= 8'h00;
			parser_code_ff <= 8'h00;
			parser_subcode_ff <= 8'h00;
			index_ff <= 8'h00;
			idx_seen_ff <= 1'b0;
		end else if (rx_start) begin
			armed_ff <= state_ff == rci_pkg::RCI_IDLE;
			pos_ff <= 8'h00;
			parser_code_ff <= 8'h00;
			parser_subcode_ff <= 8'h00;
			index_ff <= 8'h00;
			idx_seen_ff <= 1'b0;
		end else if (rx_end) begin
			armed_ff <= 1'b0;
		end else if (rx_mvalid && armed_ff) begin
			pos_ff <= 8'(pos_ff + 8'd1);
			if (pos_ff == 8'd0) begin
				command_class_code_ff <= rx_mbyte;
			end else if (pos_ff == 8'd1) begin
				parser_code_ff <= rx_mbyte;
			end else if (pos_ff == 8'd2) begin
				parser_subcode_ff <= rx_mbyte;
			end else if (pos_ff == 8'd3 && ((command_class_code_ff == rci_pkg::CMD_SET && indexed) // [R7]
				|| command_class_code_ff == rci_pkg::CMD_QUERY)) begin // [R10]
				index_ff <= rx_mbyte;
				idx_seen_ff <= 1'b1;
			end
		end
	end

	// Set data is only staged here; the store applies it on commit
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SET_WR_OUT <= 1'b0;
			SET_WADDR_OUT <= 7'h00;
			SET_WDATA_OUT <= 8'h00;
		end else begin
			SET_WR_OUT <= rx_mvalid && armed_ff && command_class_code_ff == rci_pkg::CMD_SET && pos_ff >= hdr_len
				&& settable && sub_one; // [R6] [R14]
			SET_WADDR_OUT <= data_cnt[6:0];
			SET_WDATA_OUT <= rx_mbyte;
		end
	end

	// Command dispatch and sequencing
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_ff <= rci_pkg::RCI_IDLE;
			status_ff <= rci_pkg::STAT_OK;
			multi_ff <= 1'b0;
			post_ff <= 1'b0;
			post_boot_ff <= 1'b0;
			post_kind_ff <= 8'h00;
			SET_COMMIT_OUT <= 1'b0;
			SET_LEN_OUT <= 8'h00;
			QUERY_REQ_OUT <= 1'b0;
			RESET_REQ_OUT <= 1'b0;
			RESET_KIND_OUT <= 8'h00;
			BOOT_MODE_OUT <= 1'b0;
			CODE_OUT <= 8'h00;
			SUB_OUT <= 8'h00;
			INDEX_OUT <= 8'h00;
			INDEXED_OUT <= 1'b0;
		end else begin
			SET_COMMIT_OUT <= 1'b0;
			QUERY_REQ_OUT <= 1'b0;
			RESET_REQ_OUT <= 1'b0;
			case (state_ff)
				rci_pkg::RCI_IDLE: begin
					post_ff <= 1'b0;
					if (frame_go) begin
						CODE_OUT <= parser_code_ff;
						SUB_OUT <= parser_subcode_ff;
						INDEX_OUT <= index_ff;
						INDEXED_OUT <= idx_seen_ff;
						state_ff <= rci_pkg::RCI_ACK_LOAD;
						status_ff <= rci_pkg::STAT_BAD_CODE; // [R19]
						if (command_class_code_ff == rci_pkg::CMD_SET) begin
							if (!sub_one || !settable) begin
								status_ff <= rci_pkg::STAT_BAD_CODE; // [R14] [R19]
							end else if (pos_ff <= hdr_len) begin
								status_ff <= rci_pkg::STAT_BAD_LEN;
							end else begin
								SET_COMMIT_OUT <= 1'b1; // [R6]
								SET_LEN_OUT <= data_cnt;
								state_ff <= rci_pkg::RCI_SET_WAIT;
							end
						end else if (command_class_code_ff == rci_pkg::CMD_QUERY) begin
							if (pos_ff != rci_pkg::HDR_LEN_PLAIN && pos_ff != rci_pkg::HDR_LEN_INDEXED) begin
								status_ff <= rci_pkg::STAT_BAD_LEN;
							end else if (code_ok && (sub_one || sub_all) && idx_ok) begin // [R9] [R10]
								QUERY_REQ_OUT <= 1'b1;
								multi_ff <= sub_all || (idx_seen_ff && index_ff == rci_pkg::SELECT_ALL);
								state_ff <= rci_pkg::RCI_QRY_WAIT;
							end
						end else if (command_class_code_ff == rci_pkg::CMD_SYSTEM) begin
							if (pos_ff != rci_pkg::SYS_CMD_LEN) begin
								status_ff <= rci_pkg::STAT_BAD_LEN;
							end else if (sys_sub_ok) begin
								status_ff <= rci_pkg::STAT_OK; // [R11] [R20]
								post_ff <= 1'b1;
								post_boot_ff <= parser_code_ff == rci_pkg::RST_BOOTLOADER;
								post_kind_ff <= parser_code_ff;
							end
						end
					end
				end
				rci_pkg::RCI_SET_WAIT: begin
					if (SET_DONE_IN) begin
						status_ff <= SET_OK_IN ? rci_pkg::STAT_OK : rci_pkg::STAT_FAIL; // [R5] [R8]
						state_ff <= rci_pkg::RCI_ACK_LOAD; // [R1]
					end
				end
				rci_pkg::RCI_QRY_WAIT: begin
					if (QUERY_DONE_IN) begin
						status_ff <= QUERY_OK_IN ? rci_pkg::STAT_OK : rci_pkg::STAT_FAIL; // [R4] [R5]
						if (QUERY_OK_IN && !multi_ff && !QUERY_MULTI_IN) begin
							state_ff <= rci_pkg::RCI_IDLE; // [R2]
						end else begin
							state_ff <= rci_pkg::RCI_ACK_LOAD; // [R3] [R4]
						end
					end
				end
				rci_pkg::RCI_ACK_LOAD: begin
					state_ff <= rci_pkg::RCI_ACK_SEND;
				end
				rci_pkg::RCI_ACK_SEND: begin
					if (tx_last_acc) begin
						state_ff <= post_ff ? rci_pkg::RCI_POST : rci_pkg::RCI_IDLE;
					end
				end
				rci_pkg::RCI_POST: begin
					// Reached only after the acknowledgment has fully left
					if (post_boot_ff) begin
						BOOT_MODE_OUT <= 1'b1; // [R12] [R20]
					end else begin
						RESET_REQ_OUT <= 1'b1; // [R20]
						RESET_KIND_OUT <= post_kind_ff;
					end
					state_ff <= rci_pkg::RCI_IDLE;
				end
				default: state_ff <= rci_pkg::RCI_IDLE;
			endcase
		end
	end

	// Serial settings follow the mode; bootloader mode is left only by reset
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			BAUD_RATE_OUT <= NORMAL_BAUD;
			PARITY_EVEN_OUT <= 1'b0;
		end else begin
			BAUD_RATE_OUT <= BOOT_MODE_OUT ? rci_pkg::BOOT_BAUD_BPS : NORMAL_BAUD; // [R12]
			PARITY_EVEN_OUT <= BOOT_MODE_OUT; // [R12]
		end
	end

	// Acknowledgment transmitter with escape stuffing
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tx_idx_ff <= 4'd0;
			tx_half_ff <= 1'b0;
			TX_BYTE_OUT <= 8'h00;
			TX_VALID_OUT <= 1'b0;
		end else if (state_ff == rci_pkg::RCI_ACK_LOAD) begin
			tx_idx_ff <= 4'd0;
			tx_half_ff <= 1'b0;
			TX_BYTE_OUT <= rci_pkg::FRAME_START_BYTE; // [R15]
			TX_VALID_OUT <= 1'b1;
		end else if (tx_acc) begin
			if (tx_half_ff) begin
				TX_BYTE_OUT <= cur_byte & rci_pkg::CODE_MAX; // [R17]
				tx_half_ff <= 1'b0;
			end else if (tx_idx_ff == rci_pkg::ACK_LAST_IDX) begin
				TX_VALID_OUT <= 1'b0;
			end else begin
				tx_idx_ff <= next_idx;
				if (next_idx >= rci_pkg::STUFF_FIRST_IDX && next_idx <= rci_pkg::STUFF_LAST_IDX
					&& next_byte >= rci_pkg::ESCAPE_BYTE && next_byte <= rci_pkg::CTRL_MAX) begin
					TX_BYTE_OUT <= rci_pkg::ESCAPE_BYTE; // [R17]
					tx_half_ff <= 1'b1;
				end else begin
					TX_BYTE_OUT <= next_byte; // [R1] [R16]
				end
			end
		end
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RST_IN);

	a_ack_parser_code: assert property (TX_VALID_OUT && tx_idx_ff == 4'd1 |-> TX_BYTE_OUT == 8'h10) // [R1]
		else $error("Acknowledgment parser code is not 0x10");
	a_single_no_ack: assert property ((state_ff == rci_pkg::RCI_QRY_WAIT && QUERY_DONE_IN && QUERY_OK_IN // [R2]
		&& !multi_ff && !QUERY_MULTI_IN) |=> state_ff == rci_pkg::RCI_IDLE ##1 !TX_VALID_OUT)
		else $error("Single report query produced an acknowledgment");
	a_multi_ack: assert property ((state_ff == rci_pkg::RCI_QRY_WAIT && QUERY_DONE_IN && QUERY_OK_IN // [R3]
		&& (multi_ff || QUERY_MULTI_IN)) |=> state_ff == rci_pkg::RCI_ACK_LOAD ##1 (TX_VALID_OUT && TX_BYTE_OUT == 8'h81))
		else $error("Multi report query not closed by acknowledgment");
	a_fail_ack: assert property ((state_ff == rci_pkg::RCI_QRY_WAIT && QUERY_DONE_IN && !QUERY_OK_IN) // [R4]
		|=> (state_ff == rci_pkg::RCI_ACK_LOAD && status_ff == 8'h01))
		else $error("Failed query not acknowledged with fail status");
	a_set_status: assert property ((state_ff == rci_pkg::RCI_SET_WAIT && SET_DONE_IN) // [R5]
		|=> status_ff == ($past(SET_OK_IN) ? 8'h00 : 8'h01))
		else $error("Set acknowledgment status does not follow the store");
	a_commit_valid: assert property (SET_COMMIT_OUT |-> $past(rx_end && rx_ok && settable)) // [R16]
		else $error("Set committed without a valid frame");
	a_boot_silent: assert property (BOOT_MODE_OUT |-> (!QUERY_REQ_OUT && !SET_COMMIT_OUT && !RESET_REQ_OUT)) // [R13]
		else $error("Command acted on in bootloader mode");
	a_boot_link: assert property ($rose(BOOT_MODE_OUT) |=> (BAUD_RATE_OUT == 18'd115200 && PARITY_EVEN_OUT)) // [R12]
		else $error("Bootloader link settings wrong");
	a_reset_after_ack: assert property (RESET_REQ_OUT |-> $past(tx_last_acc, 2)) // [R20]
		else $error("Reset issued before acknowledgment finished");
	a_stuff_low: assert property ((tx_acc && TX_BYTE_OUT == 8'h80) |=> (TX_VALID_OUT && TX_BYTE_OUT <= 8'h07)) // [R17]
		else $error("Escape not followed by low seven bits");
	a_unknown_err: assert property ((frame_go && command_class_code_ff > 8'h03) // [R19]
		|=> (state_ff == rci_pkg::RCI_ACK_LOAD && status_ff == 8'h02 && !SET_COMMIT_OUT))
		else $error("Unknown command not rejected");

	c_single_query: cover property (state_ff == rci_pkg::RCI_QRY_WAIT && QUERY_DONE_IN && QUERY_OK_IN && !multi_ff);
	c_multi_query: cover property (state_ff == rci_pkg::RCI_QRY_WAIT && QUERY_DONE_IN && multi_ff);
	c_set_done: cover property (state_ff == rci_pkg::RCI_SET_WAIT && SET_DONE_IN && SET_OK_IN);
	c_boot_entry: cover property ($rose(BOOT_MODE_OUT));
	c_stuffed_tx: cover property (tx_acc && tx_half_ff);
endmodule : rci_cmd_interp
`default_nettype wire

// ===== verilog/rci_pkg.sv
// Shared constants and types of the receiver command interpreter
package rci_pkg;
	localparam logic [7:0] FRAME_START_BYTE = 8'h81;
	localparam logic [7:0] FRAME_END_BYTE = 8'h82;
	localparam logic [7:0] ESCAPE_BYTE = 8'h80;
	localparam logic [7:0] CTRL_MAX = 8'h87;
	localparam logic [7:0] CTRL_LOW_MAX = 8'h07;
	localparam logic [7:0] CODE_MAX = 8'h7F;
	localparam logic [7:0] SELECT_ALL = 8'hFF;
	localparam logic [7:0] CMD_SET = 8'h01;
	localparam logic [7:0] CMD_QUERY = 8'h02;
	localparam logic [7:0] CMD_SYSTEM = 8'h03;
	localparam logic [7:0] ACK_PARSER_CODE = 8'h10;
	localparam logic [7:0] ACK_PARSER_SUBCODE = 8'h00;
	localparam logic [7:0] RST_PLAIN = 8'h01;
	localparam logic [7:0] RST_CLEAR_RAM = 8'h02;
	localparam logic [7:0] RST_BOOTLOADER = 8'h03;
	localparam logic [7:0] RST_CLEAR_EPH = 8'h05;
	localparam logic [7:0] RST_CLEAR_FLASH = 8'h07;
	localparam logic [7:0] RST_SAVE_BBM = 8'h09;
	localparam logic [7:0] STAT_OK = 8'h00;
	localparam logic [7:0] STAT_FAIL = 8'h01;
	localparam logic [7:0] STAT_BAD_CODE = 8'h02;
	localparam logic [7:0] STAT_BAD_LEN = 8'h03;
	// Frame positions counted in M-bytes; deframer counts include the start byte, header and command lengths do not
	localparam logic [7:0] MAX_MBYTES = 8'd134;
	localparam logic [7:0] ESC_MIN_CNT = 8'd3;
	localparam logic [7:0] MIN_FRAME_CNT = 8'd3;
	localparam logic [7:0] HDR_LEN_PLAIN = 8'd3;
	localparam logic [7:0] HDR_LEN_INDEXED = 8'd4;
	localparam logic [7:0] SYS_CMD_LEN = 8'd2;
	localparam logic [3:0] ACK_LAST_IDX = 4'd8;
	localparam logic [3:0] STUFF_FIRST_IDX = 4'd2;
	localparam logic [3:0] STUFF_LAST_IDX = 4'd7;
	localparam logic [17:0] BOOT_BAUD_BPS = 18'd115200;
	localparam logic [17:0] NORMAL_BAUD_BPS = 18'd9600;
	typedef enum logic [2:0] {
		RCI_IDLE,
		RCI_SET_WAIT,
		RCI_QRY_WAIT,
		RCI_ACK_LOAD,
		RCI_ACK_SEND,
		RCI_POST
	} rci_state_t;
endpackage : rci_pkg

// ===== verilog/rci_rx_deframe.sv
// Receive deframer: start/end detection, unstuffing, checksum and length checks
`timescale 1ns/10ps
`default_nettype none
module rci_rx_deframe (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] byte_in,
	input wire logic valid_in,
	output logic [7:0] mbyte_out,
	output logic mvalid_out,
	output logic start_out,
	output logic end_out,
	output logic ok_out
);
	logic in_frame_ff, esc_ff, pend_vld_ff;
	logic [7:0] sum_ff, cnt_ff, pend_ff;
	logic is_start, is_end, is_esc, is_ctrl, plain, abort, sum_good;
	logic [7:0] mbyte;

	always_comb begin
		is_start = byte_in == rci_pkg::FRAME_START_BYTE;
		is_end = byte_in == rci_pkg::FRAME_END_BYTE;
		is_esc = byte_in == rci_pkg::ESCAPE_BYTE;
		is_ctrl = (byte_in > rci_pkg::FRAME_END_BYTE) && (byte_in <= rci_pkg::CTRL_MAX);
		plain = !is_start && !is_end && !is_esc && !is_ctrl;
		mbyte = esc_ff ? (byte_in | rci_pkg::ESCAPE_BYTE) : byte_in; // [R18]
		sum_good = 8'(sum_ff + rci_pkg::FRAME_END_BYTE) == 8'h00; // [R16]
		abort = valid_in && in_frame_ff && ((is_esc && (esc_ff || cnt_ff < rci_pkg::ESC_MIN_CNT)) || is_ctrl
			|| (plain && ((esc_ff && byte_in > rci_pkg::CTRL_LOW_MAX) || cnt_ff >= 8'(rci_pkg::MAX_MBYTES - 8'd1))));
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			in_frame_ff <= 1'b0;
			esc_ff <= 1'b0;
			sum_ff <= 8'h00;
			cnt_ff <= 8'h00;
			pend_ff <= 8'h00;
			pend_vld_ff <= 1'b0;
			mbyte_out <= 8'h00;
			mvalid_out <= 1'b0;
			start_out <= 1'b0;
			end_out <= 1'b0;
			ok_out <= 1'b0;
		end else begin
			mvalid_out <= 1'b0;
			start_out <= 1'b0;
			end_out <= 1'b0;
			if (valid_in && is_start) begin
				// A second start closes the open frame as failed
				end_out <= in_frame_ff;
				ok_out <= 1'b0;
				in_frame_ff <= 1'b1;
				esc_ff <= 1'b0;
				sum_ff <= rci_pkg::FRAME_START_BYTE;
				cnt_ff <= 8'd1;
				pend_vld_ff <= 1'b0;
				start_out <= 1'b1;
			end else if (abort) begin
				in_frame_ff <= 1'b0;
				end_out <= 1'b1;
				ok_out <= 1'b0;
			end else if (valid_in && in_frame_ff && is_end) begin
				in_frame_ff <= 1'b0;
				end_out <= 1'b1;
				ok_out <= sum_good && !esc_ff && pend_vld_ff && cnt_ff >= rci_pkg::MIN_FRAME_CNT; // [R16] [R15]
			end else if (valid_in && in_frame_ff && is_esc) begin
				esc_ff <= 1'b1; // [R18]
			end else if (valid_in && in_frame_ff) begin
				// The newest byte is held back: at the end byte it is the checksum
				sum_ff <= 8'(sum_ff + mbyte);
				cnt_ff <= 8'(cnt_ff + 8'd1);
				esc_ff <= 1'b0;
				pend_ff <= mbyte;
				pend_vld_ff <= 1'b1;
				mvalid_out <= pend_vld_ff;
				mbyte_out <= pend_ff;
			end
		end
	end

	a_bad_sum_rejects: assert property (@(posedge clk_in) disable iff (rst_in) // [R16]
		(valid_in && in_frame_ff && is_end && !sum_good) |=> (end_out && !ok_out))
		else $error("Frame with bad checksum accepted");
	a_escape_merges: assert property (@(posedge clk_in) disable iff (rst_in) // [R18]
		(valid_in && in_frame_ff && esc_ff && plain && !abort) |=> (pend_ff == ($past(byte_in) | 8'h80)))
		else $error("Escaped byte not recovered with top bit set");
endmodule : rci_rx_deframe
`default_nettype wire
